// file: include/sfp_pkg.sv
// Purpose: shared constants for the serial flash protect/status block
// Assumes: 25 MHz aclk, link clock sampled in the aclk domain
// Notes: status word is 24 bits, three bytes low to high
//
// Behaviour
// - hold pin low pauses transfer, keeps position
// - paused: output released, clock and input ignored
// - pause edges count only with clock low
// - select rising during pause resets device state
// - soft reset needs 66h then 99h back-to-back
// - soft reset recovery rejects all instructions
// - top config bit picks pause or reset pin
// - reset pin low resets, aborts, blocks instructions
// - quad enable disables pause and reset functions
// - reset pin overrides every other input
// - deep power-down accepts only release instruction
// - write commands rejected during power-up delay
// - latch cleared by reset, disable, writes, erases
// - latch zero refuses writes; enable sets it
// - busy flag high during program, erase, status write
// - block protect field guards chip erase only; program, sector and block erase are not checked
// - chip erase only with matching complement setting
// - protect mode 00 gates on latch only, 01 on latch and pin
// - protect mode 10 locks until power cycle
// - protect mode 11 locks status until power cycle
// - suspend sets suspend status bit, resume clears it
// - security lock bits are one-time settable
// - power cycle turns mode 10 into 00
package sfp_pkg;
  // instruction codes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_RDSR1 = 8'h05;
  localparam logic [7:0] CMD_RDSR2 = 8'h35;
  localparam logic [7:0] CMD_RDSR3 = 8'h15;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_SE = 8'h20;
  localparam logic [7:0] CMD_BE = 8'hD8;
  localparam logic [7:0] CMD_CE = 8'hC7;
  localparam logic [7:0] CMD_SUSP = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_DPD = 8'hB9;
  localparam logic [7:0] CMD_RDPD = 8'hAB;
  localparam logic [7:0] CMD_RSTEN = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  // status bit positions
  localparam int BIT_BUSY = 0;
  localparam int BIT_WEL = 1;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_SPM0 = 7;
  localparam int BIT_SPM1 = 8;
  localparam int BIT_QE = 9;
  localparam int BIT_LB_LO = 11;
  localparam int BIT_CMP = 14;
  localparam int BIT_SUS = 15;
  localparam int BIT_PRS = 23;
  // status reset value: drive strength 10, all else 0
  localparam logic [23:0] STATUS_RST = 24'h400000;
  // mask of bits the status write may change (spm, bp, qe, cmp, drv, prs)
  localparam logic [23:0] STATUS_WMASK = 24'hE043FC;
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int RECOV_US = 300;
  localparam int RECOV_CYC = RECOV_US * (CLK_HZ / 1000000);
  localparam int RSTPIN_NS = 1000;
  localparam int RSTPIN_CYC = (RSTPIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int PUDLY_US = 10;
  localparam int PUDLY_CYC = PUDLY_US * (CLK_HZ / 1000000);
  localparam int BUSY_CYC = 64;
  localparam int SCK_DIV = 4;
  // controller register map (axi-lite, byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TXRX = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_PINS = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: include/sfp_if.sv
`timescale 1ns/1ns
// Purpose: serial link between flash controller and flash device
// Assumes: host drives clock, select, input data; device drives output
// Notes: shared pin is three signals per end; wire level is the resolved pair
interface sfp_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic wp_n;
  logic hold_o;
  logic hold_oe;
  logic hold_dev_o;
  logic hold_dev_oe;
  logic hold_wire;
  // pulled high when nobody drives
  assign hold_wire = hold_oe ? hold_o : (hold_dev_oe ? hold_dev_o : 1'b1);
  modport host (output sck, output cs_n, output mosi, input miso, input miso_oe,
                output wp_n, output hold_o, output hold_oe, input hold_wire);
  modport dev (input sck, input cs_n, input mosi, output miso, output miso_oe,
               input wp_n, output hold_dev_o, output hold_dev_oe, input hold_wire);
endinterface

// file: hw/sfp_sync.sv
`timescale 1ns/1ns
// Purpose: two-flop synchroniser, one per bit
// Assumes: inputs asynchronous to aclk
// Notes: first stage read only by second
module sfp_sync #(parameter int W = 4, parameter logic [W-1:0] INIT = '1) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  // two stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= INIT;
      q <= INIT;
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule

// file: hw/sfp_dev.sv
`timescale 1ns/1ns
// Purpose: flash device end: pause/reset pin, write latch, protection, status
// Assumes: mode 0 serial, first byte an instruction, array engine modelled as busy count
// Notes: power cycle is modelled by aresetn; nonvolatile bits held in flip-flops
module sfp_dev #(parameter int RECOV_CYCLES = sfp_pkg::RECOV_CYC,
                 parameter int PUDLY_CYCLES = sfp_pkg::PUDLY_CYC) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  sfp_if.dev link,
  // observation
  output logic [23:0] status,
  output logic paused,
  output logic in_reset
);
  typedef enum logic [1:0] {SFP_IDLE, SFP_CMD, SFP_DATA, SFP_SKIP} sfp_ph_e;
  typedef struct packed {
    sfp_ph_e ph;
    logic [2:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [1:0] nbyte;
    logic [7:0] tx;
    logic miso;
    logic [23:0] sr;
    logic rst_armed;
    logic dpd;
    logic paused;
    logic sck_q;
    logic cs_q;
    logic [15:0] recov;
    logic [15:0] pudly;
    logic [7:0] busy;
    logic [7:0] rpin_cnt;
    logic pin_rst;
  } sfp_dev_s;
  sfp_dev_s st_r, st_nxt;
  logic sck_s, cs_s, mosi_s, wp_s, hold_s;
  logic quad, pause_fn, reset_fn, can_wr_sr, prot_lock, gate, sck_rise, sck_fall;
  logic [7:0] byte_in;
  logic [23:0] newsr;
  sfp_sync #(.W(5), .INIT(5'h0B)) u_sync ( // idle: sck low, cs high, pins high
    .aclk(aclk), .aresetn(aresetn),
    .d({link.sck, link.cs_n, link.mosi, link.wp_n, link.hold_wire}),
    .q({sck_s, cs_s, mosi_s, wp_s, hold_s}));
  // shared pin function
  assign quad = st_r.sr[sfp_pkg::BIT_QE];
  assign pause_fn = !quad && !st_r.sr[sfp_pkg::BIT_PRS];
  assign reset_fn = !quad && st_r.sr[sfp_pkg::BIT_PRS];
  assign sck_rise = sck_s && !st_r.sck_q;
  assign sck_fall = !sck_s && st_r.sck_q;
  assign byte_in = {st_r.sh[6:0], mosi_s};
  // status-write permission by protect mode
  always_comb begin
    case ({st_r.sr[sfp_pkg::BIT_SPM1], st_r.sr[sfp_pkg::BIT_SPM0]})
      2'b00: can_wr_sr = 1'b1;
      2'b01: can_wr_sr = wp_s;
      2'b10: can_wr_sr = 1'b0;
      default: can_wr_sr = 1'b0;
    endcase
  end
  assign prot_lock = st_r.sr[sfp_pkg::BIT_SPM0] && !wp_s;
  // instruction decode blocked by recovery and reset pin; power-up delay checked per write command
  assign gate = (st_r.recov == 16'h0000) && !st_r.pin_rst;
  // next status after a status write
  always_comb begin
    // byte replicated so each of the three bytes lands in its own slice
    newsr = (st_r.sr & ~sfp_pkg::STATUS_WMASK) | ({3{byte_in}} & sfp_pkg::STATUS_WMASK);
    newsr[sfp_pkg::BIT_LB_LO +: 3] = st_r.sr[sfp_pkg::BIT_LB_LO +: 3]
      | byte_in[sfp_pkg::BIT_LB_LO - 8 +: 3];
    if (prot_lock) begin
      newsr[sfp_pkg::BIT_BP_LO +: 5] = st_r.sr[sfp_pkg::BIT_BP_LO +: 5];
    end
    newsr[sfp_pkg::BIT_WEL] = 1'b0;
    newsr[sfp_pkg::BIT_BUSY] = 1'b1;
  end
  // main sequence
  always_comb begin
    st_nxt = st_r;
    st_nxt.sck_q = sck_s;
    st_nxt.cs_q = cs_s;
    if (st_r.recov != 16'h0000) st_nxt.recov = st_r.recov - 16'h0001;
    if (st_r.pudly != 16'h0000) st_nxt.pudly = st_r.pudly - 16'h0001;
    if (st_r.busy != 8'h00) st_nxt.busy = st_r.busy - 8'h01;
    if (st_r.busy == 8'h01) st_nxt.sr[sfp_pkg::BIT_BUSY] = 1'b0;
    // hold pin enters/leaves pause only with clock low
    if (pause_fn && !cs_s && !sck_s) st_nxt.paused = !hold_s;
    if (!pause_fn) st_nxt.paused = 1'b0;
    // reset pin width filter
    if (reset_fn && !hold_s) begin
      if (st_r.rpin_cnt < 8'(sfp_pkg::RSTPIN_CYC)) st_nxt.rpin_cnt = st_r.rpin_cnt + 8'h01;
    end else begin
      st_nxt.rpin_cnt = 8'h00;
    end
    st_nxt.pin_rst = reset_fn && !hold_s && st_r.rpin_cnt >= 8'(sfp_pkg::RSTPIN_CYC - 1);
    if (cs_s) begin
      st_nxt.ph = SFP_IDLE;
      st_nxt.bitcnt = 3'h0;
      st_nxt.nbyte = 2'h0;
      if (st_r.paused) begin
        st_nxt.paused = 1'b0;
        st_nxt.busy = 8'h00;
        st_nxt.sr[sfp_pkg::BIT_BUSY] = 1'b0;
        st_nxt.rst_armed = 1'b0;
      end
      // latch cleared again at deselect after a status write's bytes; each byte applied at its eighth bit
      if (st_r.ph == SFP_DATA && st_r.cmd == sfp_pkg::CMD_WRSR && st_r.nbyte != 2'h0) begin
        st_nxt.sr[sfp_pkg::BIT_WEL] = 1'b0;
      end
    end else if (!st_r.paused && st_r.ph == SFP_IDLE && st_r.cs_q) begin
      st_nxt.ph = gate ? SFP_CMD : SFP_SKIP;
    end else if (!st_r.paused && sck_rise && (st_r.ph == SFP_CMD || st_r.ph == SFP_DATA)) begin
      st_nxt.sh = byte_in;
      st_nxt.bitcnt = st_r.bitcnt + 3'h1;
      if (st_r.bitcnt == 3'h7 && st_r.ph == SFP_CMD) begin
        st_nxt.cmd = byte_in;
        st_nxt.ph = SFP_SKIP;
        if (byte_in != sfp_pkg::CMD_RST) st_nxt.rst_armed = 1'b0;
        if (st_r.dpd) begin
          if (byte_in == sfp_pkg::CMD_RDPD) st_nxt.dpd = 1'b0;
        end else begin
          case (byte_in)
            sfp_pkg::CMD_RSTEN: st_nxt.rst_armed = 1'b1;
            sfp_pkg::CMD_RST: begin
              if (st_r.rst_armed) begin
                st_nxt.sr = (st_r.sr & ~24'h008003) | 24'h000000;
                st_nxt.busy = 8'h00;
                st_nxt.recov = 16'(RECOV_CYCLES);
                st_nxt.rst_armed = 1'b0;
              end
            end
            sfp_pkg::CMD_WREN:
              if (st_r.pudly == 16'h0000) st_nxt.sr[sfp_pkg::BIT_WEL] = 1'b1;
            sfp_pkg::CMD_WRDI: st_nxt.sr[sfp_pkg::BIT_WEL] = 1'b0;
            sfp_pkg::CMD_RDSR1, sfp_pkg::CMD_RDSR2, sfp_pkg::CMD_RDSR3: begin
              st_nxt.ph = SFP_DATA;
              st_nxt.tx = (byte_in == sfp_pkg::CMD_RDSR1) ? st_r.sr[7:0] :
                          (byte_in == sfp_pkg::CMD_RDSR2) ? st_r.sr[15:8] : st_r.sr[23:16];
            end
            sfp_pkg::CMD_WRSR:
              if (st_r.sr[sfp_pkg::BIT_WEL] && can_wr_sr && st_r.pudly == 16'h0000
                  && !st_r.sr[sfp_pkg::BIT_BUSY]) begin
                st_nxt.ph = SFP_DATA;
              end else begin
                st_nxt.sr[sfp_pkg::BIT_WEL] = 1'b0;
              end
            sfp_pkg::CMD_PP, sfp_pkg::CMD_SE, sfp_pkg::CMD_BE, sfp_pkg::CMD_CE: begin
              // array engine abstracted; only chip erase checks the protect field, against cmp
              if (st_r.sr[sfp_pkg::BIT_WEL] && st_r.pudly == 16'h0000
                  && !st_r.sr[sfp_pkg::BIT_BUSY]
                  && (byte_in != sfp_pkg::CMD_CE
                      || st_r.sr[sfp_pkg::BIT_BP_LO +: 3]
                         == {3{st_r.sr[sfp_pkg::BIT_CMP]}})) begin
                st_nxt.sr[sfp_pkg::BIT_BUSY] = 1'b1;
                st_nxt.busy = 8'(sfp_pkg::BUSY_CYC);
              end
              st_nxt.sr[sfp_pkg::BIT_WEL] = 1'b0;
            end
            sfp_pkg::CMD_SUSP: st_nxt.sr[sfp_pkg::BIT_SUS] = 1'b1;
            sfp_pkg::CMD_RESUME: st_nxt.sr[sfp_pkg::BIT_SUS] = 1'b0;
            sfp_pkg::CMD_DPD: st_nxt.dpd = 1'b1;
            default: st_nxt.ph = SFP_SKIP;
          endcase
        end
      end else if (st_r.bitcnt == 3'h7 && st_r.cmd == sfp_pkg::CMD_WRSR) begin
        st_nxt.nbyte = st_r.nbyte + 2'h1;
        // each byte applies cumulatively: low, mid, high
        if (st_r.nbyte == 2'h0) st_nxt.sr[7:2] = newsr[7:2];
        if (st_r.nbyte == 2'h1) st_nxt.sr[15:8] = newsr[15:8];
        if (st_r.nbyte == 2'h2) st_nxt.sr[23:16] = newsr[23:16];
        st_nxt.sr[sfp_pkg::BIT_WEL] = 1'b0;
        st_nxt.sr[sfp_pkg::BIT_BUSY] = 1'b1;
        st_nxt.busy = 8'(sfp_pkg::BUSY_CYC);
      end
    end else if (!st_r.paused && sck_fall && st_r.ph == SFP_DATA
                 && st_r.cmd != sfp_pkg::CMD_WRSR) begin
      st_nxt.miso = st_r.tx[7];
      st_nxt.tx = {st_r.tx[6:0], st_r.tx[7]};
    end
    // reset pin wins over everything
    if (st_r.pin_rst) begin
      st_nxt.sr = st_r.sr & ~24'h008003;
      st_nxt.busy = 8'h00;
      st_nxt.ph = SFP_SKIP;
      st_nxt.paused = 1'b0;
      st_nxt.rst_armed = 1'b0;
      st_nxt.dpd = 1'b0;
    end
  end
  // state register; power-on state from aresetn
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.sr <= sfp_pkg::STATUS_RST;
      st_r.sck_q <= 1'b0;
      st_r.cs_q <= 1'b1;
      st_r.ph <= SFP_IDLE;
      st_r.pudly <= 16'(PUDLY_CYCLES);
    end else begin
      st_r <= st_nxt;
    end
  end
  // outputs
  assign link.miso = st_r.miso;
  assign link.miso_oe = !cs_s && !st_r.paused && st_r.ph == SFP_DATA;
  assign link.hold_dev_o = 1'b0;
  assign link.hold_dev_oe = 1'b0;
  assign status = st_r.sr;
  assign paused = st_r.paused;
  assign in_reset = !gate;
endmodule

// file: hw/sfp_host.sv
`timescale 1ns/1ns
// Purpose: host controller end: axi-lite registers drive serial frames
// Assumes: mode 0, one byte per TXRX write
// Notes: pin bits in PINS register drive wp_n and the shared pin
module sfp_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi-lite slave
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // serial link
  sfp_if.host link
);
  typedef struct packed {
    logic aw_ok;
    logic [3:0] awa;
    logic w_ok;
    logic [31:0] wd;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic cs_n;
    logic sck;
    logic mosi;
    logic [3:0] pins;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] edges;
    logic run;
    logic [7:0] div;
  } sfp_host_s;
  sfp_host_s st_r, st_nxt;
  logic miso_s, miso_oe_s, hold_s;
  sfp_sync #(.W(3), .INIT(3'h1)) u_sync (
    .aclk(aclk), .aresetn(aresetn),
    .d({link.miso, link.miso_oe, link.hold_wire}), .q({miso_s, miso_oe_s, hold_s}));
  assign s_awready = !st_r.aw_ok && !st_r.bv;
  assign s_wready = !st_r.w_ok && !st_r.bv;
  assign s_arready = !st_r.rv;
  // bus and shifter
  always_comb begin
    st_nxt = st_r;
    if (s_awvalid && s_awready) begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.awa = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      st_nxt.w_ok = 1'b1;
      st_nxt.wd = s_wdata;
    end
    if (st_r.aw_ok && st_r.w_ok) begin
      st_nxt.aw_ok = 1'b0;
      st_nxt.w_ok = 1'b0;
      st_nxt.bv = 1'b1;
      st_nxt.br = sfp_pkg::RESP_OKAY;
      case (st_r.awa)
        sfp_pkg::REG_CTRL: if (s_wstrb[0]) st_nxt.cs_n = !st_r.wd[0];
        sfp_pkg::REG_TXRX:
          if (st_r.run || st_r.cs_n) begin
            st_nxt.br = sfp_pkg::RESP_SLVERR;
          end else if (s_wstrb[0]) begin
            st_nxt.tx = st_r.wd[7:0];
            st_nxt.run = 1'b1;
            st_nxt.edges = 4'h0;
            st_nxt.mosi = st_r.wd[7];
          end
        sfp_pkg::REG_PINS: if (s_wstrb[0]) st_nxt.pins = st_r.wd[3:0];
        sfp_pkg::REG_STAT: st_nxt.br = sfp_pkg::RESP_SLVERR;
        default: st_nxt.br = sfp_pkg::RESP_SLVERR;
      endcase
    end
    if (st_r.bv && s_bready) st_nxt.bv = 1'b0;
    if (s_arvalid && s_arready) begin
      st_nxt.rv = 1'b1;
      st_nxt.rr = sfp_pkg::RESP_OKAY;
      case (s_araddr)
        sfp_pkg::REG_CTRL: st_nxt.rd = {31'h0, !st_r.cs_n};
        sfp_pkg::REG_TXRX: st_nxt.rd = {24'h0, st_r.rx};
        sfp_pkg::REG_STAT: st_nxt.rd = {29'h0, hold_s, miso_oe_s, st_r.run};
        sfp_pkg::REG_PINS: st_nxt.rd = {28'h0, st_r.pins};
        default: begin
          st_nxt.rd = 32'h0;
          st_nxt.rr = sfp_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rv && s_rready) st_nxt.rv = 1'b0;
    // serial clock from divider; frozen while PINS bit 2 is low
    if (st_r.run && st_r.pins[2]) begin
      if (st_r.div == 8'(sfp_pkg::SCK_DIV - 1)) begin
        st_nxt.div = 8'h00;
        st_nxt.sck = !st_r.sck;
        st_nxt.edges = st_r.edges + 4'h1;
        // miso taken at the fall: sync delays push the new bit past the rise
        if (st_r.sck) begin
          st_nxt.rx = {st_r.rx[6:0], miso_s};
          st_nxt.tx = {st_r.tx[6:0], 1'b0};
          st_nxt.mosi = st_r.tx[6];
        end
        if (st_r.edges == 4'hF) st_nxt.run = 1'b0;
      end else begin
        st_nxt.div = st_r.div + 8'h01;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.cs_n <= 1'b1;
      st_r.pins <= 4'h7;
    end else begin
      st_r <= st_nxt;
    end
  end
  // link outputs; pause pin only changes while sck low by software order
  assign link.sck = st_r.sck;
  assign link.cs_n = st_r.cs_n;
  assign link.mosi = st_r.mosi;
  assign link.wp_n = st_r.pins[0];
  assign link.hold_o = st_r.pins[2] && st_r.pins[1];
  assign link.hold_oe = 1'b1;
  assign s_bresp = st_r.br;
  assign s_bvalid = st_r.bv;
  assign s_rdata = st_r.rd;
  assign s_rresp = st_r.rr;
  assign s_rvalid = st_r.rv;
endmodule

// file: tb/sfp_checker.sv
`timescale 1ns/1ns
// Purpose: link and status checker for the controller/device pair
// Assumes: one aclk domain, status word seen at the device end
// Notes: instantiated beside the link interface, no bind
module sfp_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic wp_n,
  input wire logic hold_wire,
  // device observation
  input wire logic [23:0] status,
  input wire logic paused,
  input wire logic in_reset
);
  logic [7:0] busy_cnt_r;
  logic [7:0] busy_cnt_nxt;
  // length of the current busy run
  always_comb begin
    busy_cnt_nxt = status[0] ? busy_cnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge aclk) begin
    busy_cnt_r <= aresetn ? busy_cnt_nxt : 8'h00;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pause_out_off: assert property (paused && $past(paused) |-> !miso_oe)
    else $error("output driven while paused");
  a_pause_sck_low: assert property ($rose(paused) |-> !sck && !$past(sck, 4))
    else $error("pause entered with clock high");
  a_pause_deselect: assert property (paused && cs_n |-> ##[1:4] !paused)
    else $error("deselect did not end pause");
  a_quad_no_pause: assert property (status[9] && $past(status[9]) |-> !paused)
    else $error("pause with quad enable set");
  a_busy_wel_clear: assert property ($rose(status[0]) |-> !status[1])
    else $error("latch still set at busy start");
  a_busy_run_len: assert property ($fell(status[0]) && !in_reset |->
    busy_cnt_r inside {[8'h3F:8'h41]})
    else $error("busy run length wrong");
  a_reset_wel_low: assert property (in_reset |=> !status[1])
    else $error("latch set during reset");
  a_lock_mode_hold: assert property (status[8] && $past(status[8]) |->
    $stable(status[9:2]))
    else $error("locked status bits changed");
  a_hw_lock_hold: assert property (status[8:7] == 2'b01 && $past(status[7]) &&
    !$past(status[8]) && !wp_n && !$past(wp_n, 4) |-> $stable(status[9:2]))
    else $error("status changed under pin lock");
  a_pin_reset_go: assert property ((status[23] && !status[9] && !hold_wire) [*8] |->
    ##[1:40] in_reset)
    else $error("reset pin ignored");
endmodule

// file: tb/serial_flash_protect_status_tb_top.sv
`timescale 1ns/1ns
// Purpose: self-checking bench for the controller and device pair
// Assumes: 25 MHz aclk, short recovery and power-up counts
// Notes: host driven over axi-lite, device watched at its status port
module serial_flash_protect_status_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, paused, in_rst;
  logic saw_rst = 1'b0;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic [23:0] st;
  logic [7:0] rx;
  int mismatches = 0;
  int checked = 0;
  sfp_if link();
  sfp_dev #(.RECOV_CYCLES(20), .PUDLY_CYCLES(10)) i_sfp_dev (.aclk(aclk), .aresetn(aresetn),
    .link(link), .status(st), .paused(paused), .in_reset(in_rst));
  sfp_host i_sfp_host (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready), .link(link));
  sfp_checker i_sfp_checker (.aclk(aclk), .aresetn(aresetn), .sck(link.sck), .cs_n(link.cs_n),
    .miso_oe(link.miso_oe), .wp_n(link.wp_n), .hold_wire(link.hold_wire), .status(st),
    .paused(paused), .in_reset(in_rst));
  // clock and reset watch
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) if (in_rst) saw_rst <= 1'b1;
  //----------------------------------------
  // bus and link tasks
  //----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // handshakes judged mid-cycle, acted on at the following rising edge
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = (bvalid === 1'b1);
      resp = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    logic ar_t, r_t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = (rvalid === 1'b1);
      d = rdata;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
  endtask
  // one byte across the link, received byte into rx
  task automatic xb(input logic [7:0] b);
    logic [31:0] s;
    axw(sfp_pkg::REG_TXRX, {24'h0, b});
    do axr(sfp_pkg::REG_STAT, s); while (s[0] !== 1'b0);
    axr(sfp_pkg::REG_TXRX, s);
    rx = s[7:0];
  endtask
  task automatic fr(input logic [7:0] q[$]);
    axw(sfp_pkg::REG_CTRL, 32'h1);
    foreach (q[i]) xb(q[i]);
    axw(sfp_pkg::REG_CTRL, 32'h0);
    for (int n = 0; n < 100 && st[0] !== 1'b0; n++) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask
  // status write: low, mid, high byte
  task automatic wr(input logic [23:0] v);
    fr('{sfp_pkg::CMD_WREN});
    fr('{sfp_pkg::CMD_WRSR, v[7:0], v[15:8], v[23:16]});
  endtask
  task automatic pwr();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (15) @(posedge aclk);
  endtask
  //----------------------------------------
  // scenarios
  //----------------------------------------
  task automatic t_reset();
    chk(32'(st), 32'h400000);
    axw(sfp_pkg::REG_STAT, 32'h0);
    chk(32'(resp), 32'(sfp_pkg::RESP_SLVERR));
    fr('{sfp_pkg::CMD_RDSR3, 8'h00});
    chk(32'(rx), 32'h40);
  endtask
  task automatic t_wel();
    fr('{sfp_pkg::CMD_WRSR, 8'h1C});
    chk(32'(st), 32'h400000);
    fr('{sfp_pkg::CMD_WREN});
    chk(32'(st[1]), 32'h1);
    fr('{sfp_pkg::CMD_WRDI});
    chk(32'(st[1]), 32'h0);
  endtask
  task automatic t_prot();
    wr(24'h40001C);
    chk(32'(st), 32'h40001C);
    fr('{sfp_pkg::CMD_WREN});
    fr('{sfp_pkg::CMD_CE});
    chk(32'(st[1:0]), 32'h0);
    wr(24'h40401C);
    fr('{sfp_pkg::CMD_WREN});
    axw(sfp_pkg::REG_CTRL, 32'h1);
    xb(sfp_pkg::CMD_CE);
    axw(sfp_pkg::REG_CTRL, 32'h0);
    repeat (8) @(posedge aclk);
    chk(32'(st[0]), 32'h1);
    repeat (80) @(posedge aclk);
    wr(24'h400000);
  endtask
  task automatic t_hwlock();
    wr(24'h400080);
    axw(sfp_pkg::REG_PINS, 32'h6);
    wr(24'h40009C);
    chk(32'(st), 32'h400080);
    axw(sfp_pkg::REG_PINS, 32'h7);
    wr(24'h400000);
    chk(32'(st), 32'h400000);
  endtask
  task automatic t_lock();
    logic [23:0] m;
    for (int i = 0; i < 2; i++) begin
      m = i ? 24'h400180 : 24'h400100;
      wr(m);
      wr(24'h40001C);
      chk(32'(st), 32'(m));
      pwr();
      chk(32'(st), 32'h400000);
    end
  endtask
  task automatic t_soft();
    fr('{sfp_pkg::CMD_RSTEN});
    fr('{sfp_pkg::CMD_WREN});
    saw_rst <= 1'b0;
    fr('{sfp_pkg::CMD_RST});
    chk(32'({saw_rst, st[1]}), 32'h1);
    fr('{sfp_pkg::CMD_RSTEN});
    fr('{sfp_pkg::CMD_RST});
    chk(32'({saw_rst, st[1]}), 32'h2);
    // let the recovery count run out before the next frame
    repeat (24) @(posedge aclk);
  endtask
  task automatic t_dpd();
    fr('{sfp_pkg::CMD_DPD});
    fr('{sfp_pkg::CMD_WREN});
    chk(32'(st[1]), 32'h0);
    fr('{sfp_pkg::CMD_RDPD});
    fr('{sfp_pkg::CMD_WREN});
    chk(32'(st[1]), 32'h1);
    fr('{sfp_pkg::CMD_SUSP});
    chk(32'(st[15]), 32'h1);
    fr('{sfp_pkg::CMD_RESUME});
    chk(32'(st[15]), 32'h0);
  endtask
  task automatic t_pause();
    axw(sfp_pkg::REG_CTRL, 32'h1);
    xb(sfp_pkg::CMD_RDSR1);
    axw(sfp_pkg::REG_PINS, 32'h3);
    repeat (8) @(posedge aclk);
    chk(32'({paused, link.miso_oe}), 32'h2);
    axw(sfp_pkg::REG_PINS, 32'h7);
    repeat (8) @(posedge aclk);
    xb(8'h00);
    chk(32'(rx), 32'h02);
    axw(sfp_pkg::REG_PINS, 32'h3);
    repeat (8) @(posedge aclk);
    axw(sfp_pkg::REG_CTRL, 32'h0);
    repeat (8) @(posedge aclk);
    chk(32'(paused), 32'h0);
    axw(sfp_pkg::REG_PINS, 32'h7);
  endtask
  task automatic t_pin();
    wr(24'hC00200);
    saw_rst <= 1'b0;
    axw(sfp_pkg::REG_PINS, 32'h1);
    repeat (40) @(posedge aclk);
    chk(32'({saw_rst, paused}), 32'h0);
    axw(sfp_pkg::REG_PINS, 32'h7);
    wr(24'hC00000);
    fr('{sfp_pkg::CMD_WREN});
    axw(sfp_pkg::REG_PINS, 32'h5);
    repeat (40) @(posedge aclk);
    chk(32'({saw_rst, st[1]}), 32'h2);
    axw(sfp_pkg::REG_PINS, 32'h7);
    pwr();
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    pwr();
    t_reset();
    t_wel();
    t_prot();
    t_hwlock();
    t_lock();
    t_soft();
    t_dpd();
    fr('{sfp_pkg::CMD_WREN});
    t_pause();
    t_pin();
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge aclk);
    mismatches++;
    print_verdict();
  end
endmodule
